//--- src/pfg_pkg.sv
// Package for the port F / port G pin I/O block.
// Assumes an AXI4-Lite register bus with 32-bit data and word-aligned registers.
package pfg_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_F_DIRECTION = 8'h00;
  localparam logic [7:0] ADDR_PORT_F_PIN_LEVELS = 8'h04;
  localparam logic [7:0] ADDR_PORT_F_OUTPUT_LATCH = 8'h08;
  localparam logic [7:0] ADDR_PORT_G_DIRECTION = 8'h0c;
  localparam logic [7:0] ADDR_PORT_G_PIN_LEVELS = 8'h10;
  localparam logic [7:0] ADDR_PORT_G_OUTPUT_LATCH = 8'h14;
  localparam logic [7:0] ADDR_PORT_F_BUFFER_SEL = 8'h18;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int PORT_F_WIDTH = 8;
  localparam int PORT_G_IO_WIDTH = 5;
  localparam int PORT_G_WIDTH = 6;
  localparam logic [7:0] PORT_F_DIRECTION_RESET = 8'hff;
  localparam logic [4:0] PORT_G_DIRECTION_RESET = 5'h1f;
  localparam logic [7:0] PORT_F_LATCH_RESET = 8'h00;
  localparam logic [4:0] PORT_G_LATCH_RESET = 5'h00;
  // Bit positions of shared functions.
  localparam int F_CMP2_BIT = 1;
  localparam int F_CMP1_BIT = 2;
  localparam int F_VREF_BIT = 5;
  localparam int F_SLAVE_SEL_BIT = 7;
  localparam int G_SERIAL_CLK_BIT = 1;
  localparam int G_SERIAL_DATA_BIT = 2;
  localparam int G_SIXTH_BIT = 5;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // One pin group: output value and output enable.
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfg_drive_t;

  // Peripheral override bundle for one port.
  typedef struct packed {
    logic [7:0] own;     // Peripheral owns the pin.
    logic [7:0] force_out; // When owned: 1 drives, 0 forces input.
    logic [7:0] data;    // Peripheral output value.
  } pfg_periph_t;

endpackage : pfg_pkg

//--- src/pfg_port_io.sv
// Port F (8 bits) and port G (5 I/O pins plus one input-only pin) with registers.
// Assumes an AXI4-Lite master on aclk and pins sampled from outside this clock.
module pfg_port_io
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration fuse level and the shared peripherals.
  input wire logic master_clear_enable_cfg,
  input wire pfg_pkg::pfg_periph_t port_f_periph,
  input wire pfg_pkg::pfg_periph_t port_g_periph,
  input wire logic [7:0] port_f_analog_sel,
  // Pins.
  input wire logic [7:0] port_f_pin_in,
  output pfg_pkg::pfg_drive_t port_f_pin,
  input wire logic [5:0] port_g_pin_in,
  output pfg_pkg::pfg_drive_t port_g_pin,
  // Decoded pin inputs toward peripherals.
  output logic [7:0] port_f_digital_in,
  output logic [5:0] port_g_digital_in,
  output logic master_clear_input,
  output logic port_f_slave_sel_ttl
);

  // ---------------------------------------------------------------
  // Pin input synchronisers
  // ---------------------------------------------------------------
  logic [7:0] f_meta;
  logic [7:0] f_sync;
  logic [5:0] g_meta;
  logic [5:0] g_sync;
  logic cfg_meta;
  logic cfg_sync;

  // Two flops on every pin level; only the second stage is read.
  always_ff @(posedge aclk)
  begin
    f_meta <= port_f_pin_in;
    f_sync <= f_meta;
    g_meta <= port_g_pin_in;
    g_sync <= g_meta;
    cfg_meta <= master_clear_enable_cfg;
    cfg_sync <= cfg_meta;
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0] port_f_direction;
  logic [7:0] port_f_output_latch;
  logic [4:0] port_g_direction;
  logic [4:0] port_g_output_latch;
  logic port_f_buffer_ttl;

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic write_hit;

  // A write fires once both address and data are captured and no response waits.
  // Holding off while bvalid stands keeps a second write from landing unanswered.
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == pfg_pkg::ADDR_PORT_F_DIRECTION) || (a == pfg_pkg::ADDR_PORT_F_PIN_LEVELS) ||
                  (a == pfg_pkg::ADDR_PORT_F_OUTPUT_LATCH) || (a == pfg_pkg::ADDR_PORT_G_DIRECTION) ||
                  (a == pfg_pkg::ADDR_PORT_G_PIN_LEVELS) || (a == pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH) ||
                  (a == pfg_pkg::ADDR_PORT_F_BUFFER_SEL);
  endfunction : addr_mapped

  // Only word offsets decode; byte offsets inside a word alias to that word.
  assign write_hit = addr_mapped({aw_addr[7:2], 2'b00});

  // Address and data are taken independently, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (do_write)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (do_write)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer SLVERR.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pfg_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_hit ? pfg_pkg::RESP_OKAY : pfg_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Register updates (only byte lane 0 carries data)
  // ---------------------------------------------------------------
  // Upper byte lanes are ignored because no register is wider than eight bits.
  logic wr_lane0;
  assign wr_lane0 = do_write && w_strb[0];

  // Direction registers hold only software values; overrides never land here.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_f_direction <= pfg_pkg::PORT_F_DIRECTION_RESET;
      port_g_direction <= pfg_pkg::PORT_G_DIRECTION_RESET;
    end
    else if (wr_lane0)
    begin
      if ({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_F_DIRECTION)
      begin
        port_f_direction <= w_data[7:0];
      end
      if ({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_G_DIRECTION)
      begin
        port_g_direction <= w_data[4:0];
      end
    end
  end

  // A write to either the latch or the pin register lands in the latch.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_f_output_latch <= pfg_pkg::PORT_F_LATCH_RESET;
      port_g_output_latch <= pfg_pkg::PORT_G_LATCH_RESET;
    end
    else if (wr_lane0)
    begin
      if (({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_F_OUTPUT_LATCH) ||
          ({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_F_PIN_LEVELS))
      begin
        port_f_output_latch <= w_data[7:0];
      end
      if (({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH) ||
          ({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_G_PIN_LEVELS))
      begin
        port_g_output_latch <= w_data[4:0];
      end
    end
  end

  // Slave-select buffer choice: one selects the TTL threshold.
  // It resets to the Schmitt setting, matching the other pins of the port.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_f_buffer_ttl <= 1'b0;
    end
    else if (wr_lane0 && ({aw_addr[7:2], 2'b00} == pfg_pkg::ADDR_PORT_F_BUFFER_SEL))
    begin
      port_f_buffer_ttl <= w_data[0];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [7:0] rd_addr;
  logic [31:0] rd_word;

  // Pin reads show synchronised levels; latch reads show the latch.
  // Unmapped offsets read as zero and are flagged by the response code.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (rd_addr)
      pfg_pkg::ADDR_PORT_F_DIRECTION: rd_word[7:0] = port_f_direction;
      pfg_pkg::ADDR_PORT_F_PIN_LEVELS: rd_word[7:0] = port_f_digital_in;
      pfg_pkg::ADDR_PORT_F_OUTPUT_LATCH: rd_word[7:0] = port_f_output_latch;
      pfg_pkg::ADDR_PORT_G_DIRECTION: rd_word[4:0] = port_g_direction;
      pfg_pkg::ADDR_PORT_G_PIN_LEVELS: rd_word[5:0] = port_g_digital_in;
      pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH: rd_word[4:0] = port_g_output_latch;
      pfg_pkg::ADDR_PORT_F_BUFFER_SEL: rd_word[0] = port_f_buffer_ttl;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  // Read address is taken for one cycle, data answered on the next edge.
  // The address is decoded live, so a master must hold araddr until it is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pfg_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= addr_mapped(rd_addr) ? pfg_pkg::RESP_OKAY : pfg_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  logic [7:0] f_drive;
  logic [7:0] f_value;
  logic [4:0] g_drive;
  logic [4:0] g_value;

  // Port F: peripherals such as comparator outputs on bits 1 and 2 take over
  // the pin; analog-selected pins never drive digitally.
  always_comb
  begin
    for (int i = 0; i < pfg_pkg::PORT_F_WIDTH; i++)
    begin
      if (port_f_periph.own[i])
      begin
        f_drive[i] = port_f_periph.force_out[i];
        f_value[i] = port_f_periph.data[i];
      end
      else
      begin
        f_drive[i] = !port_f_direction[i];
        f_value[i] = port_f_output_latch[i];
      end
    end
    f_drive = f_drive & ~port_f_analog_sel;
  end

  // Port G: serial and capture/compare units override by pin ownership.
  always_comb
  begin
    for (int i = 0; i < pfg_pkg::PORT_G_IO_WIDTH; i++)
    begin
      if (port_g_periph.own[i])
      begin
        g_drive[i] = port_g_periph.force_out[i];
        g_value[i] = port_g_periph.data[i];
      end
      else
      begin
        g_drive[i] = !port_g_direction[i];
        g_value[i] = port_g_output_latch[i];
      end
    end
  end

  // Registered drive so every output leaves a flop; reset releases all pins.
  // The register costs one cycle of pin latency but keeps pad enables glitch-free.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_f_pin <= '0;
      port_g_pin <= '0;
    end
    else
    begin
      port_f_pin.out <= f_value & f_drive;
      port_f_pin.oe <= f_drive;
      port_g_pin.out <= {3'b000, g_value & g_drive};
      port_g_pin.oe <= {3'b000, g_drive};
    end
  end

  // ---------------------------------------------------------------
  // Input paths
  // ---------------------------------------------------------------
  // Schmitt thresholds sit in the pad; here analog pins read zero and the
  // sixth pin reads only when master clear is off.
  // The fuse level is synchronised like a pin because it settles outside this clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      port_f_digital_in <= 8'h00;
      port_g_digital_in <= 6'h00;
      master_clear_input <= 1'b1;
      port_f_slave_sel_ttl <= 1'b0;
    end
    else
    begin
      port_f_digital_in <= f_sync & ~port_f_analog_sel;
      port_g_digital_in[4:0] <= g_sync[4:0];
      port_g_digital_in[pfg_pkg::G_SIXTH_BIT] <= cfg_sync ? 1'b0 : g_sync[pfg_pkg::G_SIXTH_BIT];
      master_clear_input <= cfg_sync ? g_sync[pfg_pkg::G_SIXTH_BIT] : 1'b1;
      port_f_slave_sel_ttl <= port_f_buffer_ttl;
    end
  end

endmodule : pfg_port_io

//--- bench/pfg_pin_model.sv
// Far-side circuitry for one port: resolves each pin from both drivers.
// Assumes the bench supplies a level wherever the block leaves a pin free.
module pfg_pin_model
(
  input wire pfg_pkg::pfg_drive_t drive,
  input wire logic [7:0] ext,
  output logic [7:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pin shows the block's value; a free pin shows the outside level.
  assign level = (drive.oe & drive.out) | (~drive.oe & ext);
endmodule : pfg_pin_model

//--- bench/pfg_port_io_assertions.sv
// Checker for the port block: pin and bus relations over time.
// Assumes it is bound to pfg_port_io and that all of it runs on aclk.
module pfg_port_io_assertions
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic master_clear_enable_cfg,
  input wire pfg_pkg::pfg_periph_t port_g_periph,
  input wire logic [7:0] port_f_analog_sel,
  input wire pfg_pkg::pfg_drive_t port_f_pin,
  input wire pfg_pkg::pfg_drive_t port_g_pin,
  input wire logic [7:0] port_f_digital_in,
  input wire logic [5:0] port_g_digital_in,
  input wire logic master_clear_input
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  // Long holds are used so the synchroniser depth need not be exact.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_g_top; port_g_pin.oe[7:5] == 3'h0; endproperty
  a_g_top: assert property (p_g_top) else $error("port G drives above bit 4");
  property p_rst_in; $rose(aresetn) |-> port_g_pin.oe == 8'h00 && port_f_pin.oe == 8'h00; endproperty
  a_rst_in: assert property (p_rst_in) else $error("pins driven after reset");
  property p_mc_on; master_clear_enable_cfg [*5] |-> port_g_digital_in[5] == 1'h0; endproperty
  a_mc_on: assert property (p_mc_on) else $error("sixth pin read while clear on");
  property p_mc_off; !master_clear_enable_cfg [*5] |-> master_clear_input == 1'h1; endproperty
  a_mc_off: assert property (p_mc_off) else $error("clear active while disabled");
  property p_own_out;
    (port_g_periph.own[0] && port_g_periph.force_out[0]) [*2]
      |-> port_g_pin.oe[0] && port_g_pin.out[0] == $past(port_g_periph.data[0]);
  endproperty
  a_own_out: assert property (p_own_out) else $error("forced output not driven");
  property p_own_in; (port_g_periph.own[3] && !port_g_periph.force_out[3]) [*2] |-> !port_g_pin.oe[3]; endproperty
  a_own_in: assert property (p_own_in) else $error("forced input still driven");
  property p_analog; port_f_analog_sel[3] [*4] |-> !port_f_pin.oe[3] && port_f_digital_in[3] == 1'h0; endproperty
  a_analog: assert property (p_analog) else $error("analog pin used as digital");
  property p_rtop; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rtop: assert property (p_rtop) else $error("upper read bits not zero");
  property p_awpulse; s_axi_awready |=> !s_axi_awready; endproperty
  a_awpulse: assert property (p_awpulse) else $error("awready longer than a cycle");
endmodule : pfg_port_io_assertions

bind pfg_port_io pfg_port_io_assertions u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_rdata, .s_axi_rvalid,
  .master_clear_enable_cfg, .port_g_periph, .port_f_analog_sel, .port_f_pin, .port_g_pin, .port_f_digital_in,
  .port_g_digital_in, .master_clear_input);

//--- bench/pfg_port_io_tb_top.sv
// Self-checking bench for the port block over AXI4-Lite.
// Assumes pfg_pin_model loops the pins back with an outside level.
module pfg_port_io_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic master_clear_enable_cfg = 1'h0, master_clear_input, port_f_slave_sel_ttl;
  pfg_pkg::pfg_periph_t port_f_periph = 24'h0, port_g_periph = 24'h0;
  logic [7:0] port_f_analog_sel = 8'h00, port_f_pin_in, port_f_digital_in, ext_f = 8'h00, ext_g = 8'h00, g_level;
  logic [5:0] port_g_pin_in, port_g_digital_in;
  pfg_pkg::pfg_drive_t port_f_pin, port_g_pin;
  int fails = 0;
  int n_checks = 0;

  // ----------------------------------------------------------
  // Structure
  // ----------------------------------------------------------
  // Free-running clock; all stimulus moves just after its rising edge.
  always #5 aclk = ~aclk;
  pfg_port_io u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .master_clear_enable_cfg, .port_f_periph, .port_g_periph, .port_f_analog_sel, .port_f_pin_in, .port_f_pin,
    .port_g_pin_in, .port_g_pin, .port_f_digital_in, .port_g_digital_in, .master_clear_input, .port_f_slave_sel_ttl);
  pfg_pin_model u_pin_f (.drive(port_f_pin), .ext(ext_f), .level(port_f_pin_in));
  pfg_pin_model u_pin_g (.drive(port_g_pin), .ext(ext_g), .level(g_level));
  assign port_g_pin_in = g_level[5:0];

  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic timeout(input logic hung);
    if (hung)
    begin
      fails++;
      $display("[FAIL] %0t bus answer never came", $time);
      final_report();
    end
  endtask : timeout
  // Address and data go out together; each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid && n < 50);
    timeout(s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : wr
  task automatic rdx(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid && n < 50);
    timeout(s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    chk(rd, ed);
    chk(rs, er);
  endtask : rdx

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  task automatic t_reset();
    chk({port_f_pin.oe, port_g_pin.oe}, 16'h0000);
    rdx(pfg_pkg::ADDR_PORT_F_DIRECTION, 32'hff, 2'h0);
    rdx(pfg_pkg::ADDR_PORT_G_DIRECTION, 32'h1f, 2'h0);
    rdx(pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH, 32'h00, 2'h0);
  endtask : t_reset
  task automatic t_f_out();
    wr(pfg_pkg::ADDR_PORT_F_DIRECTION, 32'h00, 2'h0);
    wr(pfg_pkg::ADDR_PORT_F_OUTPUT_LATCH, 32'ha5, 2'h0);
    cyc(3);
    chk({port_f_pin.oe, port_f_pin.out}, 16'hffa5);
    rdx(pfg_pkg::ADDR_PORT_F_PIN_LEVELS, 32'ha5, 2'h0);
    wr(pfg_pkg::ADDR_PORT_F_PIN_LEVELS, 32'h3c, 2'h0);
    rdx(pfg_pkg::ADDR_PORT_F_OUTPUT_LATCH, 32'h3c, 2'h0);
  endtask : t_f_out
  // The comparator owns bit 1 while bit 3 turns analog under a high outside level.
  task automatic t_f_periph();
    @(posedge aclk);
    ext_f <= 8'hff;
    port_f_analog_sel <= 8'h08;
    port_f_periph <= {8'h02, 8'h02, 8'h02};
    cyc(6);
    chk({port_f_pin.oe[3], port_f_pin.oe[1], port_f_pin.out[1], port_f_digital_in[3]}, 4'h6);
    port_f_analog_sel <= 8'h00;
    port_f_periph <= 24'h0;
  endtask : t_f_periph
  task automatic t_g_latch();
    wr(pfg_pkg::ADDR_PORT_G_PIN_LEVELS, 32'h3f, 2'h0);
    rdx(pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH, 32'h1f, 2'h0);
    @(posedge aclk);
    ext_g <= 8'h2a;
    cyc(4);
    rdx(pfg_pkg::ADDR_PORT_G_PIN_LEVELS, 32'h2a, 2'h0);
    rdx(pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH, 32'h1f, 2'h0);
  endtask : t_g_latch
  // Bits 0 and 1 are forced out, bit 3 forced in, the rest follow software.
  task automatic t_g_override();
    wr(pfg_pkg::ADDR_PORT_G_DIRECTION, 32'h00, 2'h0);
    @(posedge aclk);
    port_g_periph <= {8'h0b, 8'h03, 8'h01};
    cyc(4);
    chk(port_g_pin.oe, 8'h17);
    chk(port_g_pin.out & port_g_pin.oe, 8'h15);
    rdx(pfg_pkg::ADDR_PORT_G_DIRECTION, 32'h00, 2'h0);
    port_g_periph <= 24'h0;
  endtask : t_g_override
  task automatic t_master_clear_input();
    @(posedge aclk);
    master_clear_enable_cfg <= 1'h1;
    ext_g <= 8'h00;
    cyc(6);
    chk({master_clear_input, port_g_digital_in[5]}, 2'h0);
    ext_g <= 8'h20;
    cyc(6);
    chk({master_clear_input, port_g_digital_in[5]}, 2'h2);
    // With clear off, master_clear_input holds high and the sixth pin reads its outside level.
    master_clear_enable_cfg <= 1'h0;
    cyc(6);
    chk({master_clear_input, port_g_digital_in[5]}, 2'h3);
  endtask : t_master_clear_input
  task automatic t_unmapped();
    wr(8'h1c, 32'h55, pfg_pkg::RESP_SLVERR);
    rdx(8'h1c, 32'h00, pfg_pkg::RESP_SLVERR);
    wr(pfg_pkg::ADDR_PORT_F_BUFFER_SEL, 32'h01, 2'h0);
    cyc(3);
    chk(port_f_slave_sel_ttl, 1'h1);
  endtask : t_unmapped
  // A mid-run reset must bring the pins back to inputs after software made them outputs.
  task automatic t_rereset();
    wr(pfg_pkg::ADDR_PORT_G_DIRECTION, 32'h00, 2'h0);
    wr(pfg_pkg::ADDR_PORT_G_OUTPUT_LATCH, 32'h15, 2'h0);
    @(posedge aclk);
    aresetn <= 1'h0;
    cyc(2);
    aresetn <= 1'h1;
    t_reset();
  endtask : t_rereset

  // Reset for two cycles, then each scenario in turn.
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_f_out();
    t_f_periph();
    t_g_latch();
    t_g_override();
    t_master_clear_input();
    t_unmapped();
    t_rereset();
    final_report();
  end
endmodule : pfg_port_io_tb_top
